/* File: core/fsk_rx_pkg.sv */
// Purpose: Shared constants and types of the FSK receive baseband block.
// Assumes: One 10 MHz clock; 32-bit plain register port.
// Notes:   Every offset and the control and readback field positions live here; sync word, length and tolerance resets are set in the module.
package fsk_rx_pkg;

  // ==========================================================
  // Register offsets.
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] POST_BW_OFFSET = 8'h04;
  localparam logic [7:0] CORR_BW_OFFSET = 8'h08;
  localparam logic [7:0] SYNC_WORD_OFFSET = 8'h0C;
  localparam logic [7:0] RECOVERY_DIV_OFFSET = 8'h10;
  localparam logic [7:0] READBACK_OFFSET = 8'h14;
  localparam logic [7:0] STATUS_OFFSET = 8'h18;

  // ==========================================================
  // Control register field positions.
  localparam int DEMOD_SEL_POS = 0;
  localparam int DEMOD_MODE_POS = 2;
  localparam int SYNC_LEN_POS = 5;
  localparam int ERR_TOL_POS = 7;
  // Readback word field positions.
  localparam int LEVEL_POS = 1;
  localparam int AMP_GAIN_POS = 8;
  localparam int FILTER_GAIN_POS = 10;

  // ==========================================================
  // Encodings.
  localparam logic [1:0] SEL_LINEAR = 2'h0;
  localparam logic [1:0] SEL_CORRELATOR = 2'h1;
  localparam logic [2:0] MODE_SYNC_A = 3'h2;
  localparam logic [2:0] MODE_SYNC_B = 3'h3;

  // ==========================================================
  // Reset values and timing counts.
  localparam logic [1:0] DEMOD_SEL_RESET = 2'h1;
  localparam logic [2:0] DEMOD_MODE_RESET = 3'h0;
  localparam logic [9:0] POST_BW_RESET = 10'h057;
  localparam logic [9:0] CORR_BW_RESET = 10'h009;
  localparam logic [9:0] RECOVERY_DIV_RESET = 10'h001;
  localparam int OVERSAMPLE = 32;
  localparam int RELEASE_CLOCKS = 9;
  localparam int BW_SHIFT = 10;
  localparam int SYNC_MAX = 24;

  // Configuration set by software.
  typedef struct packed {
    logic [1:0] err_tol;
    logic [1:0] sync_len;
    logic [2:0] demod_mode;
    logic [1:0] demod_sel;
  } ctrl_t;

  // Sync matcher states.
  typedef enum logic [1:0] {
    SYNC_HUNT = 2'b01,
    SYNC_HOLD = 2'b10
  } sync_state_t;

endpackage : fsk_rx_pkg

/* File: core/fsk_demod_sync_detect.sv */
// Purpose: FSK demodulators, clock recovery and sync word matcher.
// Assumes: Limited I/Q signs and the level thermometer arrive on clk.
// Notes:
// Operation
// - Level code sits in readback bits seven down to one.
// - Readback also carries amplifier and filter gain codes.
// - Level digitised by an eighty level seven bit flash converter.
// - Select field 01 picks correlator, 00 picks linear discriminator.
// - Two correlators at plus and minus deviation decide each bit.
// - Second order low pass with bandwidth setting over 2^10.
// - Correlator slicer threshold fixed at zero.
// - Correlator bandwidth is demod clock over four times deviation.
// - Oversampled PLL at 32 times data rate, tolerating two percent.
// - Linear mode: proportional discriminator, averaging envelope detector, slicer.
// - Linear slicer feeds the PLL; same post filter setting.
// - Compare stream with sync word and raise interrupt on match.
// - Interrupt released after nine recovered data clocks.
// - Sync detection only in demodulator mode 010 or 011.
// - Length field selects 12, 16, 20 or 24 bits.
// - Tolerance field accepts zero to three mismatched bits.
`timescale 1ns/10ps
module fsk_demod_sync_detect
  import fsk_rx_pkg::*;
#(
  parameter int LEVELS = 80,
  parameter int DW = 16
)
(
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Register port.
  input wire logic [7:0] addr,
  input wire logic [31:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rd_data,
  // Analog front end.
  input wire logic i_lim,
  input wire logic q_lim,
  input wire logic [LEVELS-2:0] level_therm,
  input wire logic [1:0] amp_gain_code,
  input wire logic [1:0] filter_gain_code,
  // Host side.
  output logic rx_data,
  output logic recovered_clock,
  output logic sync_int
);

  // ==========================================================
  // Registers.
  ctrl_t ctrl_reg;
  logic [9:0] post_filter_bandwidth_reg;
  logic [9:0] correlator_bandwidth_setting_reg;
  logic [23:0] sync_word_reg;
  logic [9:0] recovery_div_reg;
  logic [6:0] level_reg;
  logic [31:0] rd_data_reg;
  logic match_seen_reg;

  // Configuration writes.
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      ctrl_reg <= '{err_tol: 2'h0, sync_len: 2'h0, demod_mode: DEMOD_MODE_RESET,
                    demod_sel: DEMOD_SEL_RESET};
      post_filter_bandwidth_reg <= POST_BW_RESET;
      correlator_bandwidth_setting_reg <= CORR_BW_RESET;
      sync_word_reg <= 24'h000000;
      recovery_div_reg <= RECOVERY_DIV_RESET;
    end
    else if (wr_en)
    begin
      unique case (addr)
        CTRL_OFFSET: ctrl_reg <= ctrl_t'(wr_data[8:0]);
        POST_BW_OFFSET: post_filter_bandwidth_reg <= wr_data[9:0];
        CORR_BW_OFFSET: correlator_bandwidth_setting_reg <= wr_data[9:0];
        SYNC_WORD_OFFSET: sync_word_reg <= wr_data[23:0];
        RECOVERY_DIV_OFFSET: recovery_div_reg <= wr_data[9:0];
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Level digitiser.
  // flash count
  // The thermometer of 79 comparators gives 80 codes, 0 to 79.
  function automatic logic [6:0] therm_count(input logic [LEVELS-2:0] t);
    logic [6:0] n;
    n = 7'h00;
    for (int k = 0; k < LEVELS - 1; k++)
    begin
      n = n + 7'(t[k]);
    end
    return n;
  endfunction : therm_count

  // Level is registered so readback sees a stable code.
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      level_reg <= 7'h00;
    else
      level_reg <= therm_count(level_therm);
  end

  // ==========================================================
  // Readback.
  // level field
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      rd_data_reg <= 32'h00000000;
    else if (rd_en)
    begin
      unique case (addr)
        CTRL_OFFSET: rd_data_reg <= {23'h000000, ctrl_reg};
        POST_BW_OFFSET: rd_data_reg <= {22'h000000, post_filter_bandwidth_reg};
        CORR_BW_OFFSET: rd_data_reg <= {22'h000000, correlator_bandwidth_setting_reg};
        SYNC_WORD_OFFSET: rd_data_reg <= {8'h00, sync_word_reg};
        RECOVERY_DIV_OFFSET: rd_data_reg <= {22'h000000, recovery_div_reg};
        READBACK_OFFSET: rd_data_reg <= {20'h00000, filter_gain_code, amp_gain_code, level_reg, 1'b0};
        STATUS_OFFSET: rd_data_reg <= {30'h00000000, match_seen_reg, sync_int};
        default: rd_data_reg <= 32'h00000000;
      endcase
    end
    else
      rd_data_reg <= 32'h00000000;
  end

  assign rd_data = rd_data_reg;

  // ==========================================================
  // Phase rotation detector.
  // Quadrant decoded from gray I/Q into binary order, so one step forward is one quarter turn.
  logic [1:0] quad;
  logic [1:0] quad_prev_reg;
  logic [1:0] quad_samp_reg;
  logic [9:0] corr_cnt_reg;
  logic corr_tick;
  logic signed [1:0] rot_lin;
  logic signed [1:0] rot_corr;

  assign quad = {q_lim, i_lim ^ q_lim};
  assign corr_tick = (corr_cnt_reg == 10'h000);

  // Step direction between two quadrant samples.
  function automatic logic signed [1:0] step_dir(input logic [1:0] a, input logic [1:0] b);
    logic [1:0] d;
    d = b - a;
    if (d == 2'h1)
      return 2'sb01;
    else if (d == 2'h3)
      return -2'sb01;
    else
      return 2'sb00;
  endfunction : step_dir

  // correlator dwell
  // A tone at the deviation turns a quarter cycle per setting count.
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      corr_cnt_reg <= 10'h000;
      quad_samp_reg <= 2'h0;
    end
    else if (corr_tick)
    begin
      corr_cnt_reg <= correlator_bandwidth_setting_reg - 10'h001;
      quad_samp_reg <= quad;
    end
    else
      corr_cnt_reg <= corr_cnt_reg - 10'h001;
  end

  // Linear mode looks at every clock.
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      quad_prev_reg <= 2'h0;
    else
      quad_prev_reg <= quad;
  end

  assign rot_lin = step_dir(quad_prev_reg, quad);
  assign rot_corr = corr_tick ? step_dir(quad_samp_reg, quad) : 2'sb00;

  // ==========================================================
  // Correlators and discriminator.
  logic signed [DW-1:0] corr_pos_reg;
  logic signed [DW-1:0] corr_neg_reg;
  logic signed [DW-1:0] disc_lin_reg;
  logic signed [DW-1:0] demod_in;
  localparam logic signed [DW-1:0] FULL = DW'(1 <<< (DW - 3));

  // tone correlators
  // Leaky sums of hits at plus and minus deviation; output is their difference.
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      corr_pos_reg <= '0;
      corr_neg_reg <= '0;
    end
    else if (corr_tick)
    begin
      corr_pos_reg <= corr_pos_reg - (corr_pos_reg >>> 2) + ((rot_corr > 0) ? FULL >>> 2 : '0);
      corr_neg_reg <= corr_neg_reg - (corr_neg_reg >>> 2) + ((rot_corr < 0) ? FULL >>> 2 : '0);
    end
  end

  // proportional discriminator
  // Output scales with rotation rate, so with frequency.
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      disc_lin_reg <= '0;
    else
      disc_lin_reg <= (rot_lin > 0) ? FULL : (rot_lin < 0) ? -FULL : '0;
  end

  assign demod_in = (ctrl_reg.demod_sel == SEL_CORRELATOR) ? corr_pos_reg - corr_neg_reg : disc_lin_reg;

  // ==========================================================
  // Post filter.
  logic signed [DW-1:0] lpf1_reg;
  logic signed [DW-1:0] lpf2_reg;
  logic signed [DW+11:0] step1;
  logic signed [DW+11:0] step2;

  // shared bandwidth setting
  // Two cascaded poles, each moving by (x - y) * bw / 2^10.
  assign step1 = ((DW+12)'(demod_in) - (DW+12)'(lpf1_reg)) * $signed({1'b0, post_filter_bandwidth_reg});
  assign step2 = ((DW+12)'(lpf1_reg) - (DW+12)'(lpf2_reg)) * $signed({1'b0, post_filter_bandwidth_reg});

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      lpf1_reg <= '0;
      lpf2_reg <= '0;
    end
    else
    begin
      lpf1_reg <= lpf1_reg + DW'(step1 >>> BW_SHIFT);
      lpf2_reg <= lpf2_reg + DW'(step2 >>> BW_SHIFT);
    end
  end

  // ==========================================================
  // Envelope detector and slicer.
  logic signed [DW-1:0] env_hi_reg;
  logic signed [DW-1:0] env_lo_reg;
  logic signed [DW:0] env_mid;
  logic slice;

  // averaging envelope
  // Peaks decay slowly, so long runs drift the threshold; a known limitation.
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      env_hi_reg <= '0;
      env_lo_reg <= '0;
    end
    else
    begin
      env_hi_reg <= (lpf2_reg > env_hi_reg) ? lpf2_reg : env_hi_reg - (env_hi_reg >>> 8);
      env_lo_reg <= (lpf2_reg < env_lo_reg) ? lpf2_reg : env_lo_reg - (env_lo_reg >>> 8);
    end
  end

  assign env_mid = ((DW+1)'(env_hi_reg) + (DW+1)'(env_lo_reg)) >>> 1;

  assign slice = (ctrl_reg.demod_sel == SEL_CORRELATOR) ? (lpf2_reg > 0) : ((DW+1)'(lpf2_reg) > env_mid);

  // ==========================================================
  // Clock recovery.
  logic [9:0] os_cnt_reg;
  logic os_tick;
  logic [4:0] phase_reg;
  logic slice_prev_reg;
  logic bit_strobe;
  logic rx_data_reg;
  logic recovered_clock_reg;

  assign os_tick = (os_cnt_reg == 10'h000);

  // Oversample tick, one per recovery_oversample_clock period.
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      os_cnt_reg <= 10'h000;
    else if (os_tick)
      os_cnt_reg <= recovery_div_reg - 10'h001;
    else
      os_cnt_reg <= os_cnt_reg - 10'h001;
  end

  // oversampled PLL
  // Edges belong at phase 0; hold when late, skip when early. One step
  // of 32 per edge covers a two percent rate error.
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      phase_reg <= 5'h00;
      slice_prev_reg <= 1'b0;
    end
    else if (os_tick)
    begin
      slice_prev_reg <= slice;
      if ((slice != slice_prev_reg) && (phase_reg != 5'h00))
        phase_reg <= (phase_reg < 5'(OVERSAMPLE / 2)) ? phase_reg : phase_reg + 5'h02;
      else
        phase_reg <= phase_reg + 5'h01;
    end
  end

  assign bit_strobe = os_tick && (phase_reg == 5'(OVERSAMPLE / 2));

  // Data sampled mid bit; clock rises with each new bit.
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      rx_data_reg <= 1'b0;
      recovered_clock_reg <= 1'b0;
    end
    else
    begin
      if (bit_strobe)
        rx_data_reg <= slice;
      recovered_clock_reg <= (phase_reg >= 5'(OVERSAMPLE / 2));
    end
  end

  assign rx_data = rx_data_reg;
  assign recovered_clock = recovered_clock_reg;

  // ==========================================================
  // Sync word matcher.
  logic [SYNC_MAX-1:0] shift_reg;
  logic [SYNC_MAX-1:0] len_mask;
  logic [SYNC_MAX-1:0] diff;
  logic [4:0] miss;
  logic sync_enable;
  logic match;
  sync_state_t sync_state_reg;
  logic [3:0] release_cnt_reg;
  logic sync_int_reg;

  // msb first
  // The newest bit enters at bit 0, so the word's LSB lands last.
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      shift_reg <= '0;
    else if (bit_strobe)
      shift_reg <= {shift_reg[SYNC_MAX-2:0], slice};
  end

  assign len_mask = SYNC_MAX'((25'h1 << (5'd12 + {ctrl_reg.sync_len, 2'b00})) - 25'h1);

  // error tolerance
  // The arriving bit is included, so a match lands on the strobe that completes the word.
  assign diff = ({shift_reg[SYNC_MAX-2:0], slice} ^ sync_word_reg) & len_mask;
  always_comb
  begin
    miss = 5'h00;
    for (int k = 0; k < SYNC_MAX; k++)
      miss = miss + 5'(diff[k]);
  end

  assign sync_enable = (ctrl_reg.demod_mode == MODE_SYNC_A) || (ctrl_reg.demod_mode == MODE_SYNC_B);
  assign match = sync_enable && bit_strobe && (miss <= {3'h0, ctrl_reg.err_tol});

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      sync_state_reg <= SYNC_HUNT;
      release_cnt_reg <= 4'h0;
      sync_int_reg <= 1'b0;
    end
    else
    begin
      unique case (sync_state_reg)
        SYNC_HUNT:
        begin
          if (match)
          begin
            sync_state_reg <= SYNC_HOLD;
            release_cnt_reg <= 4'(RELEASE_CLOCKS);
            sync_int_reg <= 1'b1;
          end
        end
        SYNC_HOLD:
        begin
          if (bit_strobe && (release_cnt_reg == 4'h1))
          begin
            sync_state_reg <= SYNC_HUNT;
            sync_int_reg <= 1'b0;
          end
          if (bit_strobe)
            release_cnt_reg <= release_cnt_reg - 4'h1;
        end
      endcase
    end
  end

  assign sync_int = sync_int_reg;

  // Sticky match flag; a new match wins over the read that clears it.
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      match_seen_reg <= 1'b0;
    else if (match)
      match_seen_reg <= 1'b1;
    else if (rd_en && (addr == STATUS_OFFSET))
      match_seen_reg <= 1'b0;
  end

endmodule : fsk_demod_sync_detect

/* File: tb/fsk_rx_chk.sv */
// Purpose: Port-level checks of the FSK receive block.
// Assumes: Registers change only through the register port.
// Notes:   Shadows of control and divider let timing be judged from the ports.
`timescale 1ns/10ps
module fsk_rx_chk
  import fsk_rx_pkg::*;
#(
  parameter int LEVELS = 80,
  parameter int DW = 16
)
(
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Register port.
  input wire logic [7:0] addr,
  input wire logic [31:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [31:0] rd_data,
  // Front end.
  input wire logic [LEVELS-2:0] level_therm,
  input wire logic [1:0] amp_gain_code,
  input wire logic [1:0] filter_gain_code,
  // Host side.
  input wire logic rx_data,
  input wire logic recovered_clock,
  input wire logic sync_int
);
  // ==========================================================
  // Shadow state.
  logic [8:0] ctrl_reg;
  logic [9:0] div_reg;
  logic [15:0] hi_cnt;
  logic [15:0] hi_min;
  logic [15:0] hi_max;
  logic mode_ok;
  logic [15:0] rc_age;
  // Writes are mirrored so no internal probe is needed.
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      ctrl_reg <= {4'h0, DEMOD_MODE_RESET, DEMOD_SEL_RESET};
    else if (wr_en && addr == CTRL_OFFSET)
      ctrl_reg <= wr_data[8:0];
  end
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      div_reg <= RECOVERY_DIV_RESET;
    else if (wr_en && addr == RECOVERY_DIV_OFFSET)
      div_reg <= wr_data[9:0];
  end
  // High time of the interrupt; phase jumps allow one tick per bit either way.
  always_ff @(posedge clk)
  begin
    if (!reset_n || !sync_int)
      hi_cnt <= 16'h0;
    else
      hi_cnt <= hi_cnt + 16'h1;
  end
  // Age of the recovered clock's high phase; data lands less than one oversample tick after it rises.
  always_ff @(posedge clk)
  begin
    if (!reset_n || !recovered_clock)
      rc_age <= 16'h0;
    else
      rc_age <= rc_age + 16'h1;
  end
  assign hi_min = 16'(div_reg) * 16'h0117;
  assign hi_max = 16'(div_reg) * 16'h0129;
  assign mode_ok = ctrl_reg[4:2] == MODE_SYNC_A || ctrl_reg[4:2] == MODE_SYNC_B;

  // ==========================================================
  // Assertions.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  level_code_a: assert property ($stable(level_therm) && rd_en && addr == READBACK_OFFSET
    |=> rd_data[7:1] == 7'($countones($past(level_therm))) && !rd_data[0])
    else $error("level code wrong in readback");
  gain_fields_a: assert property (rd_en && addr == READBACK_OFFSET
    |=> rd_data[31:8] == {20'h0, $past(filter_gain_code), $past(amp_gain_code)})
    else $error("gain codes wrong in readback");
  ctrl_shadow_a: assert property (rd_en && addr == CTRL_OFFSET
    |=> rd_data == {23'h0, $past(ctrl_reg)})
    else $error("control read differs from last write");
  rx_strobe_a: assert property ($changed(rx_data) |-> recovered_clock && rc_age < 16'(div_reg))
    else $error("data changed away from bit strobe");
  int_strobe_a: assert property ($rose(sync_int) |-> $past(recovered_clock))
    else $error("interrupt rose away from bit strobe");
  status_bit_a: assert property (rd_en && addr == STATUS_OFFSET |=> rd_data[0] == $past(sync_int))
    else $error("status does not mirror interrupt");
  int_width_a: assert property ($fell(sync_int) |-> hi_cnt >= hi_min && hi_cnt <= hi_max)
    else $error("interrupt width not nine bits");
  sync_mode_a: assert property ($rose(sync_int) |-> mode_ok)
    else $error("match outside sync modes");
endmodule : fsk_rx_chk

bind fsk_demod_sync_detect fsk_rx_chk #(.LEVELS(LEVELS), .DW(DW)) chk (.clk(clk), .reset_n(reset_n),
  .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
  .level_therm(level_therm), .amp_gain_code(amp_gain_code), .filter_gain_code(filter_gain_code),
  .rx_data(rx_data), .recovered_clock(recovered_clock), .sync_int(sync_int));

/* File: tb/fsk_tone_source.sv */
// Purpose: Far-end transmitter turning bits into limited I/Q signs.
// Assumes: A quarter turn per clock; positive rotation sends a one.
// Notes:   Sixteen preamble bits, the word, then alternating bits forever.
`timescale 1ns/10ps
module fsk_tone_source
(
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Frame request.
  input wire logic go,
  input wire logic [23:0] word,
  input wire logic [4:0] nbits,
  input wire logic [7:0] bit_clks,
  // Limited I/Q signs.
  output logic i_lim,
  output logic q_lim
);
  logic [1:0] phase_reg;
  logic [7:0] cnt_reg;
  logic [5:0] idx_reg;
  logic sending_reg;
  logic cur_bit;
  // Idle alternates so the recovery loop always has edges to track.
  // word goes MSB first
  assign cur_bit = (sending_reg && idx_reg >= 6'h10) ? word[int'(nbits) + 15 - int'(idx_reg)] : ~idx_reg[0];
  // Phase turns one quadrant a clock, direction set by the bit.
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      phase_reg <= 2'h0;
    else
      phase_reg <= cur_bit ? phase_reg + 2'h1 : phase_reg - 2'h1;
  end
  // Bit timing and frame sequencing.
  always_ff @(posedge clk)
  begin
    if (!reset_n || go)
    begin
      cnt_reg <= 8'h0;
      idx_reg <= 6'h0;
      sending_reg <= go;
    end
    else if (cnt_reg == bit_clks - 8'h1)
    begin
      cnt_reg <= 8'h0;
      idx_reg <= idx_reg + 6'h1;
      if (idx_reg == 6'(nbits) + 6'h0F)
        sending_reg <= 1'b0;
    end
    else
      cnt_reg <= cnt_reg + 8'h1;
  end
  assign i_lim = phase_reg == 2'h0 || phase_reg == 2'h3;
  assign q_lim = !phase_reg[1];
endmodule : fsk_tone_source

/* File: tb/tb_fsk_demod_sync_detect.sv */
// Purpose: Self-checking bench of the FSK receive block.
// Assumes: Bit period of 64 clocks (divider 2); quarter turn per clock.
// Notes:   Frames run a fixed length, so waits follow the source model.
`timescale 1ns/10ps
module tb_fsk_demod_sync_detect
  import fsk_rx_pkg::*;
();
  `define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_fail++; \
    $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wr_data = 32'h0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [78:0] level_therm = '0;
  logic [1:0] amp_gain_code = 2'h0;
  logic [1:0] filter_gain_code = 2'h0;
  logic go = 1'b0;
  logic [23:0] word = 24'h0;
  logic [4:0] nbits = 5'h0;
  logic [7:0] bit_clks = 8'h40;
  logic [31:0] rd_data;
  logic i_lim;
  logic q_lim;
  logic rx_data;
  logic recovered_clock;
  logic sync_int;
  logic si_q = 1'b0;
  // gain pairs of the host correction table, amplifier code then filter code.
  logic [3:0] gt[6] = '{4'hE, 4'hA, 4'h9, 4'h8, 4'h4, 4'h0};
  localparam logic [23:0] W = 24'hF38CE1;
  int n_fail = 0;
  int num_checks = 0;
  int rises = 0;
  int hi_len = 0;

  always #50 clk = ~clk;

  fsk_demod_sync_detect dut (.clk(clk), .reset_n(reset_n), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .i_lim(i_lim), .q_lim(q_lim),
    .level_therm(level_therm), .amp_gain_code(amp_gain_code), .filter_gain_code(filter_gain_code),
    .rx_data(rx_data), .recovered_clock(recovered_clock), .sync_int(sync_int));
  fsk_tone_source src (.clk(clk), .reset_n(reset_n), .go(go), .word(word), .nbits(nbits),
    .bit_clks(bit_clks), .i_lim(i_lim), .q_lim(q_lim));

  // ==========================================================
  // Interrupt rise count and high time; each frame measures from its own baseline.
  always @(posedge clk)
  begin
    si_q <= sync_int;
    if (sync_int && !si_q)
      rises <= rises + 1;
    if (sync_int)
      hi_len <= hi_len + 1;
  end

  // ==========================================================
  // Register port tasks.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    `CHK(nm, e, rd_data)
  endtask : rd
  function automatic logic [31:0] ctrl(input logic [1:0] s, input logic [2:0] m, input logic [1:0] l,
    input logic [1:0] t);
    return {23'h0, t, l, m, s};
  endfunction : ctrl
  // The wait covers preamble, word and sixteen idle bits at the nominal rate.
  task automatic frame(input logic [23:0] w, input logic [4:0] n, input int exp_rises, input string nm);
    int r0;
    int h0;
    @(posedge clk);
    word <= w;
    nbits <= n;
    go <= 1'b1;
    r0 = rises;
    h0 = hi_len;
    @(posedge clk);
    go <= 1'b0;
    repeat ((32 + int'(n)) * 64) @(posedge clk);
    `CHK(nm, exp_rises, rises - r0)
    if (exp_rises == 1)
      `CHK("int width", 9, (hi_len - h0 + 32) / 64)
    $display("test %s done", nm);
  endtask : frame
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test

  // ==========================================================
  // Main sequence.
  initial
  begin
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    rd(CTRL_OFFSET, 32'h1, "ctrl");
    rd(POST_BW_OFFSET, 32'(POST_BW_RESET), "post bw");
    rd(CORR_BW_OFFSET, 32'(CORR_BW_RESET), "corr bw");
    wr(POST_BW_OFFSET, 32'hFFFF_FFFF);
    rd(POST_BW_OFFSET, 32'h3FF, "post bw");
    wr(CORR_BW_OFFSET, 32'hFFFF_FFFF);
    rd(CORR_BW_OFFSET, 32'h3FF, "corr bw");
    wr(8'h1C, 32'hFFFF_FFFF);
    rd(8'h1C, 32'h0, "unmapped");
    $display("test registers done");
    // Every gain pair of the correction table, level up to full scale.
    // host power math needs the raw code, so the field is checked unscaled.
    for (int i = 0; i < 6; i++)
    begin
      @(posedge clk);
      {amp_gain_code, filter_gain_code} <= gt[i];
      level_therm <= ~({79{1'b1}} << (i * 15 + 4));
      repeat (3) @(posedge clk);
      rd(READBACK_OFFSET, {20'h0, gt[i][1:0], gt[i][3:2], 7'(i * 15 + 4), 1'b0}, "readback");
    end
    wr(READBACK_OFFSET, 32'h0);
    rd(READBACK_OFFSET, 32'h09E, "readback");
    $display("test readback done");
    wr(POST_BW_OFFSET, 32'h04B);
    wr(CORR_BW_OFFSET, 32'h1);
    wr(RECOVERY_DIV_OFFSET, 32'h2);
    wr(SYNC_WORD_OFFSET, 32'(W));
    wr(CTRL_OFFSET, ctrl(SEL_CORRELATOR, DEMOD_MODE_RESET, 2'h3, 2'h0));
    frame(W, 5'd24, 0, "mode off");
    for (int k = 0; k < 4; k++)
    begin
      wr(CTRL_OFFSET, ctrl(SEL_CORRELATOR, MODE_SYNC_A, 2'(k), 2'h0));
      frame(W, 5'(12 + 4 * k), 1, "length");
    end
    wr(CTRL_OFFSET, ctrl(SEL_CORRELATOR, MODE_SYNC_B, 2'h3, 2'h0));
    frame(W, 5'd24, 1, "mode b");
    rd(STATUS_OFFSET, 32'h2, "status");
    rd(STATUS_OFFSET, 32'h0, "status");
    wr(CTRL_OFFSET, ctrl(SEL_CORRELATOR, MODE_SYNC_A, 2'h3, 2'h3));
    frame(W ^ 24'h100101, 5'd24, 1, "tol 3");
    wr(CTRL_OFFSET, ctrl(SEL_CORRELATOR, MODE_SYNC_A, 2'h3, 2'h2));
    frame(W ^ 24'h100101, 5'd24, 0, "tol 2");
    // Linear path with the far end running 1.6 percent fast.
    bit_clks <= 8'h3F;
    wr(CTRL_OFFSET, ctrl(SEL_LINEAR, MODE_SYNC_A, 2'h1, 2'h0));
    frame(W, 5'd16, 1, "linear");
    finish_test();
  end

  // Watchdog well beyond the roughly 30000 cycles of the sequence.
  initial
  begin
    repeat (80000) @(posedge clk);
    n_fail++;
    $display("watchdog expired");
    finish_test();
  end
endmodule : tb_fsk_demod_sync_detect
